// >>> src/sfpf_pkg.sv
// constants and types for the serial flash pin front end
// assumes a 40 MHz system clock and an AXI4-Lite register bus
package sfpf_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] GUARD_OFS = 8'h04;
   localparam logic [7:0] TXD_OFS = 8'h08;
   localparam logic [7:0] RXD_OFS = 8'h0C;
   localparam logic [7:0] STAT_OFS = 8'h10;
   // control fields
   localparam int CTRL_QE_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_DRIVE_BIT = 3;
   // guard fields: range[2:0], top_bottom, granule, complement, status guard
   localparam int GUARD_W = 7;
   localparam int GUARD_TB_BIT = 3;
   localparam int GUARD_SEC_BIT = 4;
   localparam int GUARD_CMP_BIT = 5;
   localparam int GUARD_SRP_BIT = 6;
   // status fields
   localparam int ST_ARMED_BIT = 0;
   localparam int ST_SEL_BIT = 1;
   localparam int ST_PAUSE_BIT = 2;
   localparam int ST_BYTE_BIT = 3;
   localparam int ST_REFUSE_BIT = 4;
   localparam int ST_HWRST_BIT = 5;
   localparam int ST_WP_BIT = 6;
   localparam int ST_LOCK_BIT = 7;
   // reset values
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [6:0] GUARD_RST = 7'h00;
   localparam logic [7:0] TXD_RST = 8'h00;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // hardware reset pin least low time and its cycle count
   localparam int CLK_PERIOD_NS = 25;
   localparam int RST_MIN_NS = 1000;
   localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // lane modes
   typedef enum logic [1:0] {
      LM_SINGLE = 2'h0,
      LM_DUAL = 2'h1,
      LM_QUAD = 2'h2
   } sfpf_mode_e;
   // link state, gray along idle -> active -> paused
   typedef enum logic [1:0] {
      LS_IDLE = 2'h0,
      LS_ACTIVE = 2'h1,
      LS_PAUSED = 2'h3
   } sfpf_link_e;
endpackage

// >>> src/sfpf_front_end.sv
// serial flash pin front end: select, lanes, write guard, pause, reset pin
// assumes pins arrive asynchronously and are sampled on MCLK_I; the serial
// clock must stay well below a quarter of MCLK_I for its edges to be seen
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
module sfpf_front_end (
   input wire logic MCLK_I,
   input wire logic NRST_I,
   input wire logic SCK_I,
   input wire logic CS_N_I,
   input wire logic HW_RST_N_I,
   input wire logic DATA_LANE_0_I,
   input wire logic DATA_LANE_1_I,
   input wire logic DATA_LANE_2_I,
   input wire logic DATA_LANE_3_I,
   output logic DATA_LANE_0_O,
   output logic DATA_LANE_1_O,
   output logic DATA_LANE_2_O,
   output logic DATA_LANE_3_O,
   output logic DATA_LANE_0_OE_O,
   output logic DATA_LANE_1_OE_O,
   output logic DATA_LANE_2_OE_O,
   output logic DATA_LANE_3_OE_O,
   input wire logic [7:0] AWADDR_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   input wire logic [7:0] ARADDR_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I
);
   typedef struct packed {
      logic sck_s1, sck_s2, sck_p;
      logic csn_s1, csn_s2, csn_p;
      logic rst_s1, rst_s2;
      logic [3:0] ln_s1, ln_s2;
      logic [5:0] rst_cnt;
      logic armed;
      sfpf_pkg::sfpf_link_e link;
      logic [7:0] rx_sh, rx_byte, tx_sh;
      logic [2:0] rx_cnt, tx_cnt;
      logic [3:0] ctrl;
      logic [6:0] guard;
      logic [7:0] txd;
      logic byte_f, refuse_f, hwrst_f;
      logic [3:0] lane_o, lane_oe;
      logic aw_got, w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awrdy, wrdy, bvalid, arrdy, rvalid;
      logic [1:0] bresp, rresp;
      logic [31:0] rdata;
   } sfpf_state_s;

   sfpf_state_s s_q, s_d;

   // registered copy drives every output
   assign DATA_LANE_0_O = s_q.lane_o[0];
   assign DATA_LANE_1_O = s_q.lane_o[1];
   assign DATA_LANE_2_O = s_q.lane_o[2];
   assign DATA_LANE_3_O = s_q.lane_o[3];
   assign DATA_LANE_0_OE_O = s_q.lane_oe[0];
   assign DATA_LANE_1_OE_O = s_q.lane_oe[1];
   assign DATA_LANE_2_OE_O = s_q.lane_oe[2];
   assign DATA_LANE_3_OE_O = s_q.lane_oe[3];
   assign AWREADY_O = s_q.awrdy;
   assign WREADY_O = s_q.wrdy;
   assign BVALID_O = s_q.bvalid;
   assign BRESP_O = s_q.bresp;
   assign ARREADY_O = s_q.arrdy;
   assign RVALID_O = s_q.rvalid;
   assign RRESP_O = s_q.rresp;
   assign RDATA_O = s_q.rdata;

   // next-state logic for link, registers and bus
   always_comb begin
      logic qe, wp_n, hold_n, sel, rise, fall, cs_fall, locked, do_wr, hit;
      logic [1:0] mode;
      logic [2:0] step;
      logic [7:0] src;
      logic [3:0] dout;
      logic [31:0] stat;
      qe = 1'b0;
      wp_n = 1'b1;
      hold_n = 1'b1;
      sel = 1'b0;
      rise = 1'b0;
      fall = 1'b0;
      cs_fall = 1'b0;
      locked = 1'b0;
      do_wr = 1'b0;
      hit = 1'b0;
      mode = sfpf_pkg::LM_SINGLE;
      step = 3'd1;
      src = 8'h00;
      dout = 4'h0;
      stat = 32'h0000_0000;
      s_d = s_q;

      // two-stage synchronisers; edge history reads only the second stage
      s_d.sck_s1 = SCK_I;
      s_d.sck_s2 = s_q.sck_s1;
      s_d.sck_p = s_q.sck_s2;
      s_d.csn_s1 = CS_N_I;
      s_d.csn_s2 = s_q.csn_s1;
      s_d.csn_p = s_q.csn_s2;
      s_d.rst_s1 = HW_RST_N_I;
      s_d.rst_s2 = s_q.rst_s1;
      s_d.ln_s1 = {DATA_LANE_3_I, DATA_LANE_2_I, DATA_LANE_1_I, DATA_LANE_0_I};
      s_d.ln_s2 = s_q.ln_s1;

      qe = s_q.ctrl[sfpf_pkg::CTRL_QE_BIT];
      // lanes 2/3 are guard and pause pins unless the quad enable bit is set
      wp_n = qe | s_q.ln_s2[2];
      hold_n = qe | s_q.ln_s2[3];
      mode = s_q.ctrl[sfpf_pkg::CTRL_MODE_LSB +: 2];
      // a quad request without the enable bit falls back to single
      if (mode == sfpf_pkg::LM_QUAD && !qe) mode = sfpf_pkg::LM_SINGLE;
      if (mode == 2'h3) mode = sfpf_pkg::LM_SINGLE;
      step = (mode == sfpf_pkg::LM_QUAD) ? 3'd4 : (mode == sfpf_pkg::LM_DUAL) ? 3'd2 : 3'd1;
      sel = !s_q.csn_s2;
      rise = s_q.sck_s2 && !s_q.sck_p;
      fall = !s_q.sck_s2 && s_q.sck_p;
      cs_fall = !s_q.csn_s2 && s_q.csn_p;

      // link state machine
      unique case (s_q.link)
         sfpf_pkg::LS_IDLE: begin
            if (cs_fall) begin
               s_d.armed = 1'b1;
               s_d.link = sfpf_pkg::LS_ACTIVE;
               s_d.rx_cnt = 3'd0;
               s_d.tx_cnt = 3'd0;
            end
         end
         sfpf_pkg::LS_ACTIVE: begin
            if (!sel) begin
               s_d.link = sfpf_pkg::LS_IDLE;
            end else if (!hold_n) begin
               s_d.link = sfpf_pkg::LS_PAUSED;
            end else begin
               // inbound bits on the serial clock rising edge
               if (rise) begin
                  unique case (mode)
                     sfpf_pkg::LM_QUAD: s_d.rx_sh = {s_q.rx_sh[3:0], s_q.ln_s2};
                     sfpf_pkg::LM_DUAL: s_d.rx_sh = {s_q.rx_sh[5:0], s_q.ln_s2[1:0]};
                     default: s_d.rx_sh = {s_q.rx_sh[6:0], s_q.ln_s2[0]};
                  endcase
                  s_d.rx_cnt = s_q.rx_cnt + step;
                  if (s_q.rx_cnt + step == 3'd0) begin
                     s_d.rx_byte = s_d.rx_sh;
                     s_d.byte_f = 1'b1;
                  end
               end
               // outbound bits change on the falling edge
               if (fall) begin
                  src = (s_q.tx_cnt == 3'd0) ? s_q.txd : s_q.tx_sh;
                  s_d.tx_sh = src << step;
                  s_d.tx_cnt = s_q.tx_cnt + step;
                  s_d.lane_o = s_q.lane_o;
                  unique case (mode)
                     sfpf_pkg::LM_QUAD: s_d.lane_o = src[7:4];
                     sfpf_pkg::LM_DUAL: s_d.lane_o[1:0] = src[7:6];
                     default: s_d.lane_o[1] = src[7];
                  endcase
               end
            end
         end
         sfpf_pkg::LS_PAUSED: begin
            // shift registers and counts are left untouched here
            if (!sel) s_d.link = sfpf_pkg::LS_IDLE;
            else if (hold_n) s_d.link = sfpf_pkg::LS_ACTIVE;
         end
         default: s_d.link = sfpf_pkg::LS_IDLE;
      endcase

      // enables follow the next link state, so a float is never late
      dout = 4'h0;
      if (s_d.link == sfpf_pkg::LS_ACTIVE) begin
         if (mode == sfpf_pkg::LM_SINGLE) dout = 4'h2;
         else if (s_q.ctrl[sfpf_pkg::CTRL_DRIVE_BIT]) begin
            dout = (mode == sfpf_pkg::LM_QUAD) ? 4'hF : 4'h3;
         end
      end
      s_d.lane_oe = dout;

      // register lock: guard bit plus guard pin low
      locked = s_q.guard[sfpf_pkg::GUARD_SRP_BIT] && !wp_n;

      // bus write channel: address and data taken in either order
      if (AWVALID_I && s_q.awrdy) begin
         s_d.aw_got = 1'b1;
         s_d.aw_addr = AWADDR_I;
      end
      if (WVALID_I && s_q.wrdy) begin
         s_d.w_got = 1'b1;
         s_d.w_data = WDATA_I;
         s_d.w_strb = WSTRB_I;
      end
      if (s_q.bvalid && BREADY_I) s_d.bvalid = 1'b0;
      if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
         do_wr = s_q.w_strb[0];
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = sfpf_pkg::RESP_OKAY;
         unique case (s_q.aw_addr)
            sfpf_pkg::CTRL_OFS: if (do_wr) s_d.ctrl = s_q.w_data[3:0];
            sfpf_pkg::GUARD_OFS: begin
               if (locked) begin
                  s_d.bresp = sfpf_pkg::RESP_SLVERR;
                  s_d.refuse_f = 1'b1;
               end else if (do_wr) begin
                  s_d.guard = s_q.w_data[6:0];
               end
            end
            sfpf_pkg::TXD_OFS: if (do_wr) s_d.txd = s_q.w_data[7:0];
            sfpf_pkg::RXD_OFS: ;
            sfpf_pkg::STAT_OFS: begin
               // write one to clear; a new event in the same cycle wins, except a new byte while the byte flag is already set
               if (do_wr && s_q.w_data[sfpf_pkg::ST_BYTE_BIT] && !(s_d.byte_f && !s_q.byte_f))
                  s_d.byte_f = 1'b0;
               if (do_wr && s_q.w_data[sfpf_pkg::ST_REFUSE_BIT]) s_d.refuse_f = 1'b0;
               if (do_wr && s_q.w_data[sfpf_pkg::ST_HWRST_BIT]) s_d.hwrst_f = 1'b0;
            end
            default: s_d.bresp = sfpf_pkg::RESP_SLVERR;
         endcase
      end
      s_d.awrdy = !s_d.aw_got && !s_d.bvalid;
      s_d.wrdy = !s_d.w_got && !s_d.bvalid;

      // status word built from live state
      stat[sfpf_pkg::ST_ARMED_BIT] = s_q.armed;
      stat[sfpf_pkg::ST_SEL_BIT] = sel;
      stat[sfpf_pkg::ST_PAUSE_BIT] = (s_q.link == sfpf_pkg::LS_PAUSED);
      stat[sfpf_pkg::ST_BYTE_BIT] = s_q.byte_f;
      stat[sfpf_pkg::ST_REFUSE_BIT] = s_q.refuse_f;
      stat[sfpf_pkg::ST_HWRST_BIT] = s_q.hwrst_f;
      stat[sfpf_pkg::ST_WP_BIT] = wp_n;
      stat[sfpf_pkg::ST_LOCK_BIT] = locked;

      // bus read channel, one outstanding read
      if (s_q.rvalid && RREADY_I) s_d.rvalid = 1'b0;
      if (ARVALID_I && s_q.arrdy) begin
         hit = 1'b1;
         s_d.rvalid = 1'b1;
         s_d.rresp = sfpf_pkg::RESP_OKAY;
         s_d.rdata = 32'h0000_0000;
         unique case (ARADDR_I)
            sfpf_pkg::CTRL_OFS: s_d.rdata[3:0] = s_q.ctrl;
            sfpf_pkg::GUARD_OFS: s_d.rdata[6:0] = s_q.guard;
            sfpf_pkg::TXD_OFS: s_d.rdata[7:0] = s_q.txd;
            sfpf_pkg::RXD_OFS: s_d.rdata[7:0] = s_q.rx_byte;
            sfpf_pkg::STAT_OFS: s_d.rdata = stat;
            default: s_d.rresp = sfpf_pkg::RESP_SLVERR;
         endcase
      end
      s_d.arrdy = !s_d.rvalid && !hit;

      // reset pin overrides select, clock and lanes
      if (!s_q.rst_s2) begin
         s_d.link = sfpf_pkg::LS_IDLE;
         s_d.armed = 1'b0;
         s_d.rx_sh = 8'h00;
         s_d.tx_sh = 8'h00;
         s_d.rx_cnt = 3'd0;
         s_d.tx_cnt = 3'd0;
         s_d.lane_o = 4'h0;
         s_d.lane_oe = 4'h0;
         if (s_q.rst_cnt != 6'(sfpf_pkg::RST_MIN_CYC)) s_d.rst_cnt = s_q.rst_cnt + 6'd1;
         else s_d.hwrst_f = 1'b1;
      end else begin
         s_d.rst_cnt = 6'd0;
      end
   end

   // one register bank for the whole state
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         s_q <= '0;
         s_q.sck_s1 <= 1'b0;
         s_q.csn_s1 <= 1'b1;
         s_q.csn_s2 <= 1'b1;
         s_q.csn_p <= 1'b1;
         s_q.rst_s1 <= 1'b1;
         s_q.rst_s2 <= 1'b1;
         s_q.link <= sfpf_pkg::LS_IDLE;
         s_q.ctrl <= sfpf_pkg::CTRL_RST;
         s_q.guard <= sfpf_pkg::GUARD_RST;
         s_q.txd <= sfpf_pkg::TXD_RST;
         s_q.bresp <= sfpf_pkg::RESP_OKAY;
         s_q.rresp <= sfpf_pkg::RESP_OKAY;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// >>> test/sfpf_front_end_asserts.sv
// checker on the front end ports, bound at the foot of this file
// assumes one clock domain and registered bus answers
module sfpf_front_end_asserts (
   input wire logic MCLK_I,
   input wire logic NRST_I,
   input wire logic SCK_I,
   input wire logic CS_N_I,
   input wire logic HW_RST_N_I,
   input wire logic DATA_LANE_1_O,
   input wire logic DATA_LANE_0_OE_O,
   input wire logic DATA_LANE_1_OE_O,
   input wire logic DATA_LANE_2_OE_O,
   input wire logic DATA_LANE_3_OE_O,
   input wire logic AWVALID_I,
   input wire logic AWREADY_O,
   input wire logic WVALID_I,
   input wire logic WREADY_O,
   input wire logic BVALID_O,
   input wire logic BREADY_I,
   input wire logic ARVALID_I,
   input wire logic ARREADY_O,
   input wire logic RVALID_O,
   input wire logic RREADY_I
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!NRST_I);
   wire logic [3:0] oe;
   assign oe = {DATA_LANE_3_OE_O, DATA_LANE_2_OE_O, DATA_LANE_1_OE_O, DATA_LANE_0_OE_O};
   // six cycles leave room for the pin synchronisers
   property p_cs_float;
      CS_N_I [*6] |-> oe == 4'h0;
   endproperty
   a_cs_float: assert property (p_cs_float) else $error("lane driven unselected");
   property p_hw_rst;
      (!HW_RST_N_I) [*6] |-> oe == 4'h0;
   endproperty
   a_hw_rst: assert property (p_hw_rst) else $error("lane driven in pin reset");
   // lane 1 turns on only once selected, and moves only after a clock fall
   property p_oe_sel;
      $rose(DATA_LANE_1_OE_O) |-> !$past(CS_N_I, 2);
   endproperty
   a_oe_sel: assert property (p_oe_sel) else $error("lane on without select");
   property p_fall;
      DATA_LANE_1_OE_O && $past(DATA_LANE_1_OE_O) && $changed(DATA_LANE_1_O)
         |-> !$past(SCK_I) || !$past(SCK_I, 2) || !$past(SCK_I, 3);
   endproperty
   a_fall: assert property (p_fall) else $error("lane 1 moved off a fall");
   // write answer is seen two edges after the take, read answer one; both stand
   sequence s_wr_taken;
      AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
   endsequence
   property p_wr_resp;
      s_wr_taken |=> !AWREADY_O ##1 BVALID_O;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("late write response");
   property p_b_hold;
      BVALID_O && !BREADY_I |=> BVALID_O;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_rd_resp;
      ARVALID_I && ARREADY_O |=> RVALID_O && !ARREADY_O;
   endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("late read response");
   property p_r_hold;
      RVALID_O && !RREADY_I |=> RVALID_O;
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read response dropped");
endmodule
bind sfpf_front_end sfpf_front_end_asserts i_sfpf_front_end_asserts (
   .MCLK_I, .NRST_I, .SCK_I, .CS_N_I, .HW_RST_N_I, .DATA_LANE_1_O, .DATA_LANE_0_OE_O,
   .DATA_LANE_1_OE_O, .DATA_LANE_2_OE_O, .DATA_LANE_3_OE_O, .AWVALID_I, .AWREADY_O,
   .WVALID_I, .WREADY_O, .BVALID_O, .BREADY_I, .ARVALID_I, .ARREADY_O, .RVALID_O, .RREADY_I
);

// >>> test/sfpf_host_model.sv
// host model: select, serial clock idling high between frames, lane drive
// assumes the bench resolves lane levels from the device enables alone
module sfpf_host_model (
   input wire logic mclk,
   input wire logic [3:0] lane,
   input wire logic [3:0] oe,
   output logic sck,
   output logic cs_n,
   output logic [3:0] d,
   output logic pause_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sck = 1'b1;
      cs_n = 1'b1;
      d = 4'hF;
      pause_oe = 1'b0;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // deselect parks guard and pause pins high
   task automatic sel(input logic v);
      @(posedge mclk);
      cs_n <= v;
      if (v) d <= {2'b11, d[1:0]};
      cyc(8);
   endtask
   task automatic guard(input logic v);
      @(posedge mclk);
      d[2] <= v;
      cyc(6);
   endtask
   // one byte msb first, w lanes a beat; device lanes are read just before each fall
   task automatic xfer(input int w, input logic [7:0] tx, input bit hold, output logic [7:0] rx);
      logic [7:0] sh;
      sh = tx;
      rx = 8'h00;
      for (int b = 0; b < 8 / w; b++) begin
         @(posedge mclk);
         sck <= 1'b0;
         if (w == 4) d <= sh[7:4];
         else if (w == 2) d <= {1'b1, d[2], sh[7:6]};
         else d <= {1'b1, d[2], ~d[1], sh[7]};
         sh = sh << w;
         cyc(4);
         sck <= 1'b1;
         if (hold && b == 3) begin
            cyc(4);
            d[3] <= 1'b0;
            cyc(8);
            sck <= 1'b0;
            d[0] <= ~d[0];
            cyc(4);
            sck <= 1'b1;
            @(negedge mclk);
            pause_oe = oe[1];
            cyc(4);
            d[3] <= 1'b1;
            cyc(4);
         end
         cyc(4);
         @(negedge mclk);
         if (w == 4) rx = {rx[3:0], lane};
         else if (w == 2) rx = {rx[5:0], lane[1:0]};
         else rx = {rx[6:0], lane[1]};
      end
   endtask
endmodule

// >>> test/test_sfpf_front_end.sv
// self-checking bench: register bus tasks and host model calls
// assumes the package, the front end, checker and host model compile first
module test_sfpf_front_end;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [1:0] rsp_ok = sfpf_pkg::RESP_OKAY;
   localparam logic [1:0] rsp_err = sfpf_pkg::RESP_SLVERR;
   logic clk = 1'b0;
   logic nrst, hw_rst_n, awv, wv, bready, arv, rready;
   logic [7:0] awa, ara;
   logic [31:0] wd;
   logic [3:0] ws;
   logic sck, cs_n, pause_oe, awready, wready, bvalid, arready, rvalid;
   logic [3:0] d, lo, oe;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   wire logic [3:0] lane = (oe & lo) | (~oe & d);
   int bad_count = 0;
   int cmp_count = 0;
   always #12.5 clk = ~clk;
   sfpf_front_end i_sfpf_front_end (
      .MCLK_I(clk), .NRST_I(nrst), .SCK_I(sck), .CS_N_I(cs_n), .HW_RST_N_I(hw_rst_n),
      .DATA_LANE_0_I(lane[0]), .DATA_LANE_1_I(lane[1]), .DATA_LANE_2_I(lane[2]),
      .DATA_LANE_3_I(lane[3]), .DATA_LANE_0_O(lo[0]), .DATA_LANE_1_O(lo[1]),
      .DATA_LANE_2_O(lo[2]), .DATA_LANE_3_O(lo[3]), .DATA_LANE_0_OE_O(oe[0]),
      .DATA_LANE_1_OE_O(oe[1]), .DATA_LANE_2_OE_O(oe[2]), .DATA_LANE_3_OE_O(oe[3]),
      .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awready), .WDATA_I(wd), .WSTRB_I(ws),
      .WVALID_I(wv), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
      .BREADY_I(bready), .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(arready),
      .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready)
   );
   sfpf_host_model i_sfpf_host_model (
      .mclk(clk), .lane(lane), .oe(oe), .sck(sck), .cs_n(cs_n), .d(d), .pause_oe(pause_oe)
   );
   task automatic end_sim;
      if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   // a wait that ran out counts as a mismatch and ends the run
   task automatic tmo(input bit ok);
      if (!ok) begin
         bad_count++;
         end_sim();
      end
   endtask
   // ready is read at the falling edge, so the rising edge it decides is never raced
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      int n;
      bit pa, pw;
      pa = 1'b1;
      pw = 1'b1;
      n = 0;
      @(posedge clk);
      awa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      while ((pa || pw) && n < 40) begin
         @(negedge clk);
         pa = pa && awready !== 1'b1;
         pw = pw && wready !== 1'b1;
         @(posedge clk);
         awv <= pa;
         wv <= pw;
         n++;
      end
      do begin
         @(negedge clk);
         n++;
      end while (bvalid !== 1'b1 && n < 80);
      tmo(bvalid === 1'b1);
      @(posedge clk);
      bready <= 1'b1;
      @(negedge clk);
      chk("bresp", 32'(er), 32'(bresp));
      @(posedge clk);
      bready <= 1'b0;
   endtask
   // read, mask and compare; ready is raised a cycle late on purpose
   task automatic rd_chk(input string s, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      do begin
         @(negedge clk);
         n++;
      end while (arready !== 1'b1 && n < 40);
      tmo(arready === 1'b1);
      @(posedge clk);
      arv <= 1'b0;
      do begin
         @(negedge clk);
         n++;
      end while (rvalid !== 1'b1 && n < 80);
      tmo(rvalid === 1'b1);
      @(posedge clk);
      rready <= 1'b1;
      @(negedge clk);
      chk("rresp", 32'(er), 32'(rresp));
      chk(s, e, rdata & m);
      @(posedge clk);
      rready <= 1'b0;
   endtask
   initial begin
      logic [7:0] rx;
      logic [7:0] ctl[6] = '{8'h02, 8'h04, 8'h05, 8'h0A, 8'h0D, 8'h06};
      logic [7:0] txv[6] = '{8'hC9, 8'h96, 8'h6E, 8'h33, 8'h33, 8'h5A};
      logic [7:0] exv[6] = '{8'hC9, 8'hC9, 8'h6E, 8'hA5, 8'hA5, 8'h5A};
      int wid[6] = '{2, 4, 4, 2, 4, 1};
      bit ckr[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
      nrst <= 1'b0;
      hw_rst_n <= 1'b1;
      awv <= 1'b0;
      wv <= 1'b0;
      bready <= 1'b0;
      arv <= 1'b0;
      rready <= 1'b0;
      awa <= 8'h00;
      ara <= 8'h00;
      wd <= 32'h0000_0000;
      ws <= 4'hF;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      for (int i = 0; i < 3; i++) begin
         rd_chk("reset", 8'(i * 4), 32'hFFFF_FFFF, 32'h0000_0000, rsp_ok);
      end
      rd_chk("unmapped", 8'h14, 32'hFFFF_FFFF, 32'h0000_0000, rsp_err);
      axi_wr(8'h18, 32'h0000_0001, rsp_err);
      // single lane byte, paused part way with a stray clock
      axi_wr(sfpf_pkg::TXD_OFS, 32'h0000_00A5, rsp_ok);
      // a write without the byte lane 0 strobe leaves the register alone
      ws <= 4'hE;
      axi_wr(sfpf_pkg::TXD_OFS, 32'h0000_005A, rsp_ok);
      ws <= 4'hF;
      rd_chk("txd", sfpf_pkg::TXD_OFS, 32'hFFFF_FFFF, 32'h0000_00A5, rsp_ok);
      i_sfpf_host_model.sel(1'b0);
      i_sfpf_host_model.xfer(1, 8'h3C, 1'b1, rx);
      chk("lane1", 32'h0000_00A5, 32'(rx));
      chk("pause_oe", 32'h0000_0000, 32'(pause_oe));
      i_sfpf_host_model.sel(1'b1);
      rd_chk("rxd", sfpf_pkg::RXD_OFS, 32'h0000_00FF, 32'h0000_003C, rsp_ok);
      // dual, quad without enable, quad with enable, then driven dual, driven quad
      // and mode code 3, which runs as single; driven lanes loop back into the receiver
      for (int i = 0; i < 6; i++) begin
         axi_wr(sfpf_pkg::CTRL_OFS, 32'(ctl[i]), rsp_ok);
         i_sfpf_host_model.sel(1'b0);
         i_sfpf_host_model.xfer(wid[i], txv[i], 1'b0, rx);
         i_sfpf_host_model.sel(1'b1);
         if (ckr[i]) chk("lanes", 32'h0000_00A5, 32'(rx));
         rd_chk("rxd", sfpf_pkg::RXD_OFS, 32'h0000_00FF, 32'(exv[i]), rsp_ok);
      end
      // write guard pin against the status guard bit
      axi_wr(sfpf_pkg::CTRL_OFS, 32'h0000_0000, rsp_ok);
      i_sfpf_host_model.guard(1'b0);
      axi_wr(sfpf_pkg::GUARD_OFS, 32'h0000_0040, rsp_ok);
      axi_wr(sfpf_pkg::GUARD_OFS, 32'h0000_0047, rsp_err);
      rd_chk("guard", sfpf_pkg::GUARD_OFS, 32'hFFFF_FFFF, 32'h0000_0040, rsp_ok);
      i_sfpf_host_model.guard(1'b1);
      axi_wr(sfpf_pkg::GUARD_OFS, 32'h0000_0047, rsp_ok);
      rd_chk("guard", sfpf_pkg::GUARD_OFS, 32'hFFFF_FFFF, 32'h0000_0047, rsp_ok);
      // reset pin while selected; link stays dead until a fresh select
      i_sfpf_host_model.sel(1'b0);
      @(posedge clk);
      hw_rst_n <= 1'b0;
      repeat (sfpf_pkg::RST_MIN_CYC + 10) @(posedge clk);
      hw_rst_n <= 1'b1;
      i_sfpf_host_model.xfer(1, 8'h11, 1'b0, rx);
      rd_chk("rxd", sfpf_pkg::RXD_OFS, 32'h0000_00FF, 32'h0000_005A, rsp_ok);
      rd_chk("status", sfpf_pkg::STAT_OFS, 32'h0000_0021, 32'h0000_0020, rsp_ok);
      i_sfpf_host_model.sel(1'b1);
      i_sfpf_host_model.sel(1'b0);
      i_sfpf_host_model.xfer(1, 8'h81, 1'b0, rx);
      i_sfpf_host_model.sel(1'b1);
      chk("lane1", 32'h0000_00A5, 32'(rx));
      rd_chk("rxd", sfpf_pkg::RXD_OFS, 32'h0000_00FF, 32'h0000_0081, rsp_ok);
      end_sim();
   end
endmodule
